// ---- design/xcv_defines.vh ----
// Constants for the transceiver control-pin block.
// Assumes inclusion by bare name from the design files.
`ifndef XCV_DEFINES_VH
`define XCV_DEFINES_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define XCV_DATA_W 8
`define XCV_CNT_W 4
`define XCV_THR_W 6

// ----------------------------------------------------------------
// Serial framing states, one-hot
// ----------------------------------------------------------------
`define XCV_ST_IDLE 3'h1
`define XCV_ST_RX 3'h2
`define XCV_ST_TX 3'h4

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define XCV_LAST_BIT 4'h7
`define XCV_CNT_ZERO 4'h0
`define XCV_CNT_ONE 4'h1
`define XCV_BYTE_RESET 8'h00

`endif

// ---- design/xcv_edge.v ----
// Edge detector for one synchronous input.
// Assumes the input is already synchronous to clock.
`timescale 1ns/100ps
`default_nettype none

module xcv_edge (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Sampled level
    input wire level_in,
    // Edge strobes, valid in the cycle the new level is seen
    output wire rise,
    output wire fall
);

    reg prev;

    always @(posedge clock) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else begin
            prev <= level_in;
        end
    end

    assign rise = level_in & ~prev;
    assign fall = ~level_in & prev;

endmodule

`default_nettype wire

// ---- design/xcv_shift.v ----
// Parameterised left-shifting register with parallel load.
// Assumes load and shift are never asked in the same cycle.
`timescale 1ns/100ps
`default_nettype none

module xcv_shift #(
    parameter W = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Control
    input wire clear,
    input wire load,
    input wire [W-1:0] load_val,
    input wire shift_en,
    input wire bit_in,
    // Contents
    output reg [W-1:0] value
);

    always @(posedge clock) begin
        if (!rst_b) begin
            value <= {W{1'b0}};
        end else if (clear) begin
            value <= {W{1'b0}};
        end else if (load) begin
            value <= load_val;
        end else if (shift_en) begin
            value <= {value[W-2:0], bit_in};
        end
    end

endmodule

`default_nettype wire

// ---- design/xcv_ctrl.v ----
// Control-pin logic of an optical transceiver front end: signal-loss
// output, rate mode, transmit disable and fault latch, serial link framing.
// Assumes all inputs synchronous to clock; SDA wire resolved outside.
`timescale 1ns/100ps
`default_nettype none
`include "xcv_defines.vh"

module xcv_ctrl #(
    parameter DATA_W = `XCV_DATA_W,
    parameter THR_W = `XCV_THR_W
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Receive amplitude and signal-loss configuration
    input wire [THR_W-1:0] rx_amplitude,
    input wire [THR_W-1:0] signal_loss_threshold,
    input wire signal_loss_polarity,
    input wire signal_loss_enable,
    // Rate selection
    input wire rate_select_pin,
    input wire rate_select_bit,
    // Transmitter control and fault
    input wire tx_disable,
    input wire tx_fault_cond,
    // Serial link pins
    input wire chip_select_in,
    input wire serial_clock_in,
    input wire sda_in,
    // Read-back data from the register side
    input wire read_load,
    input wire [DATA_W-1:0] read_data,
    // Signal-loss and mode outputs
    output reg signal_loss_out,
    output reg high_bandwidth,
    output reg high_gain,
    // Transmitter outputs
    output reg tx_current_on,
    output reg fault_out,
    // Serial data line drive
    output reg sda_out,
    output reg sda_oe_b,
    // Received data and frame status
    output reg [DATA_W-1:0] rx_byte,
    output reg rx_valid,
    output reg frame_active,
    output reg contention
);

    // ------------------------------------------------------------
    // Signal loss
    // ------------------------------------------------------------
    wire below_threshold;
    wire next_signal_loss;

    assign below_threshold = rx_amplitude < signal_loss_threshold;
    // Disabled detector keeps the output deasserted
    assign next_signal_loss = signal_loss_enable &
        (signal_loss_polarity ? below_threshold : ~below_threshold);

    always @(posedge clock) begin
        if (!rst_b) begin
            signal_loss_out <= 1'b0;
        end else begin
            signal_loss_out <= next_signal_loss;
        end
    end

    // ------------------------------------------------------------
    // Rate mode
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_b) begin
            high_bandwidth <= 1'b0;
            high_gain <= 1'b1;
        end else begin
            high_bandwidth <= rate_select_pin | rate_select_bit;
            high_gain <= ~(rate_select_pin | rate_select_bit);
        end
    end

    // ------------------------------------------------------------
    // Transmitter enable and fault latch
    // ------------------------------------------------------------
    reg fault_latch;

    always @(posedge clock) begin
        if (!rst_b) begin
            tx_current_on <= 1'b0;
            fault_latch <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            tx_current_on <= ~tx_disable;
            // Condition present wins over the clear
            if (tx_fault_cond) begin
                fault_latch <= 1'b1;
            end else if (tx_disable) begin
                fault_latch <= 1'b0;
            end
            fault_out <= fault_latch | tx_fault_cond;
        end
    end

    // ------------------------------------------------------------
    // Serial pin edges
    // ------------------------------------------------------------
    wire cs_rise;
    wire cs_fall;
    wire scl_rise;
    wire scl_fall;

    xcv_edge u_cs_edge (
        .clock(clock),
        .rst_b(rst_b),
        .level_in(chip_select_in),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    xcv_edge u_scl_edge (
        .clock(clock),
        .rst_b(rst_b),
        .level_in(serial_clock_in),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    // ------------------------------------------------------------
    // Framing state machine
    // ------------------------------------------------------------
    localparam ST_IDLE = `XCV_ST_IDLE;
    localparam ST_RX = `XCV_ST_RX;
    localparam ST_TX = `XCV_ST_TX;

    reg [2:0] state;
    reg [`XCV_CNT_W-1:0] bit_cnt;
    wire [DATA_W-1:0] rx_value;
    wire [DATA_W-1:0] tx_value;
    wire in_rx;
    wire in_tx;
    wire rx_shift;
    wire tx_shift;
    wire tx_load;
    wire at_last_bit;

    assign in_rx = (state == ST_RX);
    assign in_tx = (state == ST_TX);
    // Clock and data are only looked at inside a framed cycle
    assign rx_shift = in_rx & chip_select_in & scl_rise;
    assign tx_shift = in_tx & chip_select_in & scl_fall;
    assign tx_load = in_rx & chip_select_in & read_load & (bit_cnt == `XCV_CNT_ZERO);
    assign at_last_bit = (bit_cnt == `XCV_LAST_BIT);

    xcv_shift #(
        .W(DATA_W)
    ) u_rx_shift (
        .clock(clock),
        .rst_b(rst_b),
        .clear(cs_fall),
        .load(1'b0),
        .load_val(read_data),
        .shift_en(rx_shift),
        .bit_in(sda_in),
        .value(rx_value)
    );

    xcv_shift #(
        .W(DATA_W)
    ) u_tx_shift (
        .clock(clock),
        .rst_b(rst_b),
        .clear(cs_fall),
        .load(tx_load),
        .load_val(read_data),
        .shift_en(tx_shift),
        .bit_in(1'b1),
        .value(tx_value)
    );

    always @(posedge clock) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bit_cnt <= `XCV_CNT_ZERO;
            rx_byte <= `XCV_BYTE_RESET;
            rx_valid <= 1'b0;
            frame_active <= 1'b0;
            contention <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_b <= 1'b1;
        end else begin
            rx_valid <= 1'b0;
            sda_out <= 1'b0;
            if (!chip_select_in) begin
                // Frame end: release line, back to initial state
                state <= ST_IDLE;
                bit_cnt <= `XCV_CNT_ZERO;
                frame_active <= 1'b0;
                contention <= 1'b0;
                sda_oe_b <= 1'b1;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (cs_rise) begin
                            state <= ST_RX;
                            bit_cnt <= `XCV_CNT_ZERO;
                            frame_active <= 1'b1;
                        end
                    end
                    ST_RX: begin
                        if (tx_load) begin
                            state <= ST_TX;
                            // Pull low for a zero, release for a one
                            sda_oe_b <= read_data[DATA_W-1] | contention;
                        end else if (rx_shift) begin
                            if (at_last_bit) begin
                                bit_cnt <= `XCV_CNT_ZERO;
                                rx_byte <= {rx_value[DATA_W-2:0], sda_in};
                                rx_valid <= 1'b1;
                            end else begin
                                bit_cnt <= bit_cnt + `XCV_CNT_ONE;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise && sda_oe_b && !sda_in) begin
                            // Line held low by the controller: stop driving
                            contention <= 1'b1;
                        end
                        if (tx_shift) begin
                            if (at_last_bit) begin
                                state <= ST_RX;
                                bit_cnt <= `XCV_CNT_ZERO;
                                sda_oe_b <= 1'b1;
                            end else begin
                                bit_cnt <= bit_cnt + `XCV_CNT_ONE;
                                sda_oe_b <= tx_value[DATA_W-2] | contention;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        bit_cnt <= `XCV_CNT_ZERO;
                        sda_oe_b <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ---- testbench/xcv_ctrl_chk.sv ----
// Checker on the ports of the control-pin block.
// Assumes one clock domain and a bind to every block instance.
`timescale 1ns/100ps
`default_nettype none
module xcv_ctrl_chk #(
    parameter THR_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Pin inputs
    input wire logic [THR_W-1:0] rx_amplitude,
    input wire logic [THR_W-1:0] signal_loss_threshold,
    input wire logic signal_loss_polarity,
    input wire logic signal_loss_enable,
    input wire logic rate_select_pin,
    input wire logic rate_select_bit,
    input wire logic tx_disable,
    input wire logic tx_fault_cond,
    input wire logic chip_select_in,
    // Outputs
    input wire logic signal_loss_out,
    input wire logic high_bandwidth,
    input wire logic high_gain,
    input wire logic tx_current_on,
    input wire logic fault_out,
    input wire logic sda_out,
    input wire logic sda_oe_b,
    input wire logic rx_valid,
    input wire logic frame_active,
    input wire logic contention
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_loss;
        $past(rst_b) |-> signal_loss_out == ($past(signal_loss_enable) &&
            ($past(signal_loss_polarity) == ($past(rx_amplitude) < $past(signal_loss_threshold))));
    endproperty
    a_loss: assert property (p_loss) else $error("signal loss wrong");
    property p_band;
        $past(rst_b) |-> high_bandwidth == ($past(rate_select_pin) | $past(rate_select_bit));
    endproperty
    a_band: assert property (p_band) else $error("bandwidth mode wrong");
    property p_gain;
        $past(rst_b) |-> high_gain == !($past(rate_select_pin) | $past(rate_select_bit));
    endproperty
    a_gain: assert property (p_gain) else $error("gain mode wrong");
    property p_tx;
        $past(rst_b) |-> tx_current_on == !$past(tx_disable);
    endproperty
    a_tx: assert property (p_tx) else $error("transmitter current wrong");
    property p_fault;
        tx_fault_cond || (fault_out && !tx_disable && !$past(tx_disable)) |=> fault_out;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not held");
    property p_start;
        $rose(chip_select_in) |-> ##[1:2] frame_active;
    endproperty
    a_start: assert property (p_start) else $error("frame not started");
    property p_end;
        !chip_select_in |=> !frame_active && sda_oe_b;
    endproperty
    a_end: assert property (p_end) else $error("frame not ended");
    property p_drive;
        !sda_oe_b |-> frame_active && !sda_out;
    endproperty
    a_drive: assert property (p_drive) else $error("data line driven wrongly");
    property p_cont;
        contention |-> sda_oe_b && frame_active;
    endproperty
    a_cont: assert property (p_cont) else $error("line driven in contention");
    property p_quiet;
        !chip_select_in ##1 !chip_select_in |=> !rx_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("byte taken outside frame");
endmodule
bind xcv_ctrl xcv_ctrl_chk #(.THR_W(THR_W)) u_chk (
    .clock(clock),
    .rst_b(rst_b),
    .rx_amplitude(rx_amplitude),
    .signal_loss_threshold(signal_loss_threshold),
    .signal_loss_polarity(signal_loss_polarity),
    .signal_loss_enable(signal_loss_enable),
    .rate_select_pin(rate_select_pin),
    .rate_select_bit(rate_select_bit),
    .tx_disable(tx_disable),
    .tx_fault_cond(tx_fault_cond),
    .chip_select_in(chip_select_in),
    .signal_loss_out(signal_loss_out),
    .high_bandwidth(high_bandwidth),
    .high_gain(high_gain),
    .tx_current_on(tx_current_on),
    .fault_out(fault_out),
    .sda_out(sda_out),
    .sda_oe_b(sda_oe_b),
    .rx_valid(rx_valid),
    .frame_active(frame_active),
    .contention(contention)
);
`default_nettype wire

// ---- testbench/xcv_host.sv ----
// Module controller model driving the three-wire link.
// Assumes the data wire is resolved with a pull-up outside.
`timescale 1ns/100ps
`default_nettype none
module xcv_host (
    // Clock and resolved data wire
    input wire logic clock,
    input wire logic sda_w,
    // Link pins
    output logic cs,
    output logic scl,
    output logic sda_b
);
    initial begin
        cs = 0;
        scl = 0;
        sda_b = 1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic frame(input logic on);
        @(posedge clock) cs <= on;
        cyc(3);
    endtask
    // One byte, MSB first; pull forces the line low on reads
    task automatic byte_io(input logic [7:0] tx, input logic rd, pull, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clock);
            scl <= 0;
            sda_b <= rd ? !pull : tx[i];
            cyc(3);
            scl <= 1;
            cyc(3);
            #1 rx[i] = sda_w;
        end
        @(posedge clock);
        scl <= 0;
        sda_b <= 1;
        cyc(3);
    endtask
endmodule
`default_nettype wire

// ---- testbench/xcv_ctrl_tb_top.sv ----
// Self-checking bench for the control-pin block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module xcv_ctrl_tb_top;
    logic clock = 0, rst_b = 0, pol = 1, en = 1, pin = 0, rbit = 0, dis = 1, fcond = 0, rl = 0;
    logic [5:0] amp = 0, thr = 0;
    logic [7:0] rd = 0, rx, got = 0;
    wire cs, scl, sda_b, sda_w, sl, hb, hg, ton, fo, so, soe_b, rxv, fa, cont;
    wire [7:0] rxb;
    int error_cnt = 0, checked = 0, nv = 0, n0;
    // Amplitude, threshold, pol en pin bit disable, then loss band current-on
    logic [19:0] rows [6] = '{{6'h05, 6'h06, 5'b11000, 3'b101}, {6'h06, 6'h06, 5'b11101, 3'b010},
        {6'h05, 6'h06, 5'b01010, 3'b011}, {6'h07, 6'h06, 5'b01111, 3'b110},
        {6'h00, 6'h3F, 5'b10000, 3'b001}, {6'h3F, 6'h00, 5'b00000, 3'b001}};
    assign sda_w = sda_b & (soe_b | so);
    xcv_ctrl u_dut (.clock(clock), .rst_b(rst_b), .rx_amplitude(amp),
        .signal_loss_threshold(thr), .signal_loss_polarity(pol), .signal_loss_enable(en),
        .rate_select_pin(pin), .rate_select_bit(rbit), .tx_disable(dis),
        .tx_fault_cond(fcond), .chip_select_in(cs), .serial_clock_in(scl), .sda_in(sda_w),
        .read_load(rl), .read_data(rd), .signal_loss_out(sl), .high_bandwidth(hb),
        .high_gain(hg), .tx_current_on(ton), .fault_out(fo), .sda_out(so), .sda_oe_b(soe_b),
        .rx_byte(rxb), .rx_valid(rxv), .frame_active(fa), .contention(cont));
    xcv_host u_host (.clock(clock), .sda_w(sda_w), .cs(cs), .scl(scl), .sda_b(sda_b));
    initial forever #20 clock = ~clock;
    always @(posedge clock) if (rxv === 1'b1) begin
        got <= rxb;
        nv <= nv + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic do_reset;
        @(posedge clock) rst_b <= 0;
        @(posedge clock) rst_b <= 1;
        tick(0);
        cmp("reset outputs", 8'h90, {hg, hb, fa, soe_b, cont, rxv, so, fo});
        cmp("reset levels", 8'h00, {6'h0, sl, ton});
        cmp("reset byte", 8'h00, rxb);
    endtask
    task automatic load_read(input logic [7:0] v);
        @(posedge clock);
        rd <= v;
        rl <= 1;
        @(posedge clock) rl <= 0;
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        do_reset();
        foreach (rows[i]) begin
            @(posedge clock) {amp, thr, pol, en, pin, rbit, dis} <= rows[i][19:3];
            tick(2);
            cmp("loss band tx", {5'h0, rows[i][2:0]}, {5'h0, sl, hb, ton});
            cmp("gain", {7'h0, !rows[i][1]}, {7'h0, hg});
        end
        @(posedge clock);
        dis <= 0;
        fcond <= 1;
        @(posedge clock) fcond <= 0;
        tick(3);
        cmp("fault held", 8'h01, {7'h0, fo});
        @(posedge clock) dis <= 1;
        tick(3);
        cmp("fault cleared", 8'h00, {7'h0, fo});
        @(posedge clock) fcond <= 1;
        @(posedge clock);
        fcond <= 0;
        dis <= 0;
        tick(3);
        cmp("fault set over clear", 8'h01, {7'h0, fo});
        @(posedge clock) dis <= 1;
        tick(3);
        cmp("fault cleared again", 8'h00, {7'h0, fo});
        u_host.frame(1);
        u_host.byte_io(8'hA5, 0, 0, rx);
        tick(2);
        cmp("rx byte", 8'hA5, got);
        u_host.frame(0);
        tick(0);
        cmp("frame end", 8'h00, {7'h0, fa});
        n0 = nv;
        u_host.byte_io(8'h3C, 0, 0, rx);
        tick(2);
        cmp("bytes outside frame", n0[7:0], nv[7:0]);
        u_host.frame(1);
        load_read(8'hC3);
        u_host.byte_io(8'h00, 1, 0, rx);
        cmp("read back", 8'hC3, rx);
        load_read(8'h80);
        u_host.byte_io(8'h00, 1, 1, rx);
        tick(0);
        cmp("contention", 8'h03, {6'h0, cont, soe_b});
        u_host.frame(0);
        tick(0);
        cmp("contention cleared", 8'h00, {7'h0, cont});
        do_reset();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
